// ==== rtl/pwr_temp_ctrl.sv ====
// power-down registers, deep sleep with address wake, and temperature readout
// assumes scl/sda open-drain pins, a frame sync pin and a digitised sensor code,
// all asynchronous to clk_sys_i
//
// Function
// [RL1] temperature result read only at 17h
// [RL2] result refreshed by frame count register
// [RL3] interval is update value plus one frames
// [RL4] result from gain and offset settings
// [RL5] result saturates at zero and FFh
// [RL6] bit 1 powers down temperature sensor
// [RL7] bits 7..4 power down analog functions
// [RL8] bits 3,2,0 power down; reset zero
// [RL9] system bit 7 requests all off
// [RL10] all off plus regulator off: deep sleep
// [RL11] own address in sleep clears all off
// [RL12] registers kept through power down
// [RL13] host holds video inputs low in sleep
// [RL14] system bit 6 powers down video receiver
// [RL15] system bits 5..0 further power downs
// [RL16] stored result kept while sensor off
`timescale 1ns/10ps
module pwr_temp_ctrl (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic frame_sync_i,
  input wire logic [7:0] sensor_code_i,
  output logic [7:0] temperature_result_o,
  output logic [7:0] analog_power_down_o,
  output logic [7:0] system_power_down_o,
  output logic deep_sleep_o
);
  // ****************************************
  // state
  // ****************************************
  pwr_temp_pkg::state_t st_q; // all registers
  pwr_temp_pkg::state_t st_d; // next value
  logic scl_rise; // bus clock edges
  logic scl_fall;
  logic bus_start; // start and stop conditions
  logic bus_stop;
  logic frame_edge; // one new frame
  logic upd; // result refresh strobe
  logic wake; // own address seen during sleep
  logic [7:0] rx_byte; // byte after this shift
  logic [7:0] rd_data; // read mux
  logic [7:0] eff_update; // clamped update value
  logic [13:0] prod; // code times gain
  logic signed [11:0] sum; // scaled code plus offset
  logic [7:0] sat; // saturated result
  int ref_raw; // integer reference sum, checks only
  logic [7:0] ref_sat; // reference result, checks only

  // ****************************************
  // combinational helpers
  // ****************************************
  // pin edges after the synchronisers
  always_comb begin
    scl_rise = st_q.pin.scl[1] & ~st_q.pin.scl_p;
    scl_fall = ~st_q.pin.scl[1] & st_q.pin.scl_p;
    bus_start = st_q.pin.scl[1] & st_q.pin.scl_p & st_q.pin.sda_p & ~st_q.pin.sda[1];
    bus_stop = st_q.pin.scl[1] & st_q.pin.scl_p & ~st_q.pin.sda_p & st_q.pin.sda[1];
    frame_edge = st_q.pin.frame[1] & ~st_q.pin.frame_p;
    rx_byte = {st_q.shift[6:0], st_q.pin.sda[1]};
  end

  // readout arithmetic with saturation
  always_comb begin
    prod = st_q.pin.code2 * st_q.rg.gain; // [RL4]
    sum = $signed({2'b00, prod[13:pwr_temp_pkg::GAIN_SHIFT]})
      + $signed({4'h0, st_q.rg.offset}) + pwr_temp_pkg::SENSOR_BIAS; // [RL4]
    if (sum < 0) begin
      sat = 8'h00; // below range [RL5]
    end else if (sum > $signed({4'h0, pwr_temp_pkg::TEMP_MAX})) begin
      sat = pwr_temp_pkg::TEMP_MAX; // above range [RL5]
    end else begin
      sat = sum[7:0];
    end
    // values under the valid range act as the lowest valid one
    eff_update = (st_q.rg.update < pwr_temp_pkg::UPDATE_MIN) ?
      pwr_temp_pkg::UPDATE_MIN : st_q.rg.update;
    // refresh only with sensor on and system all off bit clear
    upd = frame_edge & ~st_q.rg.analog[pwr_temp_pkg::ANA_THERM_SENSOR] // [RL6] [RL16]
      & ~st_q.rg.system[pwr_temp_pkg::SYS_ALL_OFF] & (st_q.frames >= eff_update); // [RL3]
  end

  // register read mux
  always_comb begin
    case (st_q.ptr)
      pwr_temp_pkg::REG_GAIN: rd_data = {2'b00, st_q.rg.gain};
      pwr_temp_pkg::REG_OFFSET: rd_data = st_q.rg.offset;
      pwr_temp_pkg::REG_UPDATE: rd_data = st_q.rg.update;
      pwr_temp_pkg::REG_TEMP: rd_data = st_q.rg.temp; // [RL1]
      pwr_temp_pkg::REG_ANALOG: rd_data = st_q.rg.analog;
      pwr_temp_pkg::REG_SYSTEM: rd_data = st_q.rg.system;
      default: rd_data = 8'h00; // unmapped reads zero
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    wake = 1'b0;
    // two-flop synchronisers, then previous values
    st_d.pin.scl = {st_q.pin.scl[0], scl_i};
    st_d.pin.sda = {st_q.pin.sda[0], sda_i};
    st_d.pin.frame = {st_q.pin.frame[0], frame_sync_i};
    st_d.pin.code1 = sensor_code_i;
    st_d.pin.code2 = st_q.pin.code1;
    st_d.pin.scl_p = st_q.pin.scl[1];
    st_d.pin.sda_p = st_q.pin.sda[1];
    st_d.pin.frame_p = st_q.pin.frame[1];
    // deep sleep needs both off bits
    st_d.sleep = st_q.rg.system[pwr_temp_pkg::SYS_ALL_OFF]
      & st_q.rg.system[pwr_temp_pkg::SYS_REGULATOR]; // [RL10]
    // frame counter and result refresh
    if (upd) begin
      st_d.frames = 8'h00; // interval restarts [RL3]
      st_d.rg.temp = sat; // [RL2]
    end else if (frame_edge & ~st_q.rg.system[pwr_temp_pkg::SYS_ALL_OFF]) begin
      st_d.frames = st_q.frames + 8'h01;
    end
    // serial bus slave
    if (bus_start) begin
      st_d.bus = pwr_temp_pkg::BUS_ADDR;
      st_d.bitcnt = 3'h0;
      st_d.drive = 1'b0;
      st_d.ack_on = 1'b0;
      st_d.have_ptr = 1'b0;
    end else if (bus_stop) begin
      st_d.bus = pwr_temp_pkg::BUS_IDLE;
      st_d.drive = 1'b0;
    end else begin
      case (st_q.bus)
        pwr_temp_pkg::BUS_IDLE: begin
          st_d.drive = 1'b0; // pin released
        end
        pwr_temp_pkg::BUS_ADDR: begin
          if (scl_rise) begin
            st_d.shift = rx_byte;
            st_d.bitcnt = st_q.bitcnt + 3'h1;
            if (st_q.bitcnt == 3'h7) begin
              if (rx_byte[7:1] != pwr_temp_pkg::DEV_ADDR) begin
                st_d.bus = pwr_temp_pkg::BUS_IDLE; // not ours
              end else if (st_q.sleep) begin
                wake = 1'b1; // address detector wakes the chip [RL11]
                st_d.rg.system[pwr_temp_pkg::SYS_ALL_OFF] = 1'b0; // [RL11]
                st_d.bus = pwr_temp_pkg::BUS_IDLE; // interface was off [RL10]
              end else begin
                st_d.rw = rx_byte[0];
                st_d.bus = pwr_temp_pkg::BUS_ACK;
              end
            end
          end
        end
        pwr_temp_pkg::BUS_ACK: begin
          if (scl_fall & ~st_q.ack_on) begin
            st_d.ack_on = 1'b1;
            st_d.drive = 1'b1; // pull low for acknowledge
          end else if (scl_fall) begin
            st_d.ack_on = 1'b0;
            st_d.bitcnt = 3'h0;
            if (st_q.rw) begin
              st_d.shift = rd_data;
              st_d.drive = ~rd_data[7];
              st_d.bus = pwr_temp_pkg::BUS_TX;
            end else begin
              st_d.drive = 1'b0;
              st_d.bus = pwr_temp_pkg::BUS_RX;
            end
          end
        end
        pwr_temp_pkg::BUS_RX: begin
          if (scl_rise) begin
            st_d.shift = rx_byte;
            st_d.bitcnt = st_q.bitcnt + 3'h1;
            if (st_q.bitcnt == 3'h7) begin
              st_d.bus = pwr_temp_pkg::BUS_ACK;
              if (~st_q.have_ptr) begin
                st_d.ptr = rx_byte; // first byte is the pointer
                st_d.have_ptr = 1'b1;
              end else begin
                st_d.ptr = st_q.ptr + 8'h01;
                // contents change only by writes, result refresh and wake [RL12]
                case (st_q.ptr)
                  pwr_temp_pkg::REG_GAIN: st_d.rg.gain = rx_byte[5:0];
                  pwr_temp_pkg::REG_OFFSET: st_d.rg.offset = rx_byte;
                  pwr_temp_pkg::REG_UPDATE: st_d.rg.update = rx_byte;
                  pwr_temp_pkg::REG_ANALOG: st_d.rg.analog = rx_byte; // [RL6] [RL7] [RL8]
                  pwr_temp_pkg::REG_SYSTEM: st_d.rg.system = rx_byte; // [RL9] [RL14] [RL15]
                  default: st_d.rg = st_d.rg; // result and unmapped ignore writes [RL1]
                endcase
              end
            end
          end
        end
        pwr_temp_pkg::BUS_TX: begin
          if (scl_rise) begin
            st_d.bitcnt = st_q.bitcnt + 3'h1;
            if (st_q.bitcnt == 3'h7) begin
              st_d.bus = pwr_temp_pkg::BUS_MACK;
            end
          end else if (scl_fall) begin
            st_d.shift = {st_q.shift[6:0], 1'b0};
            st_d.drive = ~st_q.shift[6];
          end
        end
        pwr_temp_pkg::BUS_MACK: begin
          if (scl_fall) begin
            st_d.drive = 1'b0; // let the host answer
          end else if (scl_rise) begin
            if (st_q.pin.sda[1]) begin
              st_d.bus = pwr_temp_pkg::BUS_IDLE; // host ended the read
            end else begin
              st_d.ptr = st_q.ptr + 8'h01;
              st_d.bus = pwr_temp_pkg::BUS_RLOAD;
            end
          end
        end
        pwr_temp_pkg::BUS_RLOAD: begin
          if (scl_fall) begin
            st_d.shift = rd_data;
            st_d.drive = ~rd_data[7];
            st_d.bitcnt = 3'h0;
            st_d.bus = pwr_temp_pkg::BUS_TX;
          end
        end
        default: st_d.bus = pwr_temp_pkg::BUS_IDLE;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      st_q <= '0;
      // bus pins rest high, so no false edge follows reset
      st_q.pin.scl <= 2'h3;
      st_q.pin.sda <= 2'h3;
      st_q.pin.scl_p <= 1'b1;
      st_q.pin.sda_p <= 1'b1;
      st_q.rg.gain <= pwr_temp_pkg::GAIN_RST;
      st_q.rg.offset <= pwr_temp_pkg::OFFSET_RST;
      st_q.rg.update <= pwr_temp_pkg::UPDATE_RST;
      st_q.rg.analog <= pwr_temp_pkg::PD_RST; // [RL8]
      st_q.rg.system <= pwr_temp_pkg::PD_RST; // [RL15]
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from state; sda_o tied low
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~st_q.drive;
  assign temperature_result_o = st_q.rg.temp;
  assign analog_power_down_o = st_q.rg.analog;
  assign system_power_down_o = st_q.rg.system;
  assign deep_sleep_o = st_q.sleep;

  // ****************************************
  // checks
  // ****************************************
  // integer reference of the readout, kept apart from the datapath above
  always_comb begin
    ref_raw = ((int'(st_q.pin.code2) * int'(st_q.rg.gain)) >> pwr_temp_pkg::GAIN_SHIFT)
      + int'(st_q.rg.offset) + int'(pwr_temp_pkg::SENSOR_BIAS);
    if (ref_raw < 0) begin
      ref_sat = 8'h00; // below range
    end else if (ref_raw > int'(pwr_temp_pkg::TEMP_MAX)) begin
      ref_sat = pwr_temp_pkg::TEMP_MAX; // above range
    end else begin
      ref_sat = ref_raw[7:0];
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  chk_temp_only_upd: assert property (!upd |=> $stable(st_q.rg.temp)) // [RL2]
    else $error("result changed without refresh");
  chk_sat_high: assert property (upd && ref_raw > int'(pwr_temp_pkg::TEMP_MAX) // [RL5]
    |=> temperature_result_o == pwr_temp_pkg::TEMP_MAX)
    else $error("high reading not saturated");
  chk_sat_low: assert property (upd && ref_raw < 0 |=> temperature_result_o == 8'h00) // [RL5]
    else $error("low reading not zero");
  chk_gain_offset: assert property (upd |=> temperature_result_o == $past(ref_sat)) // [RL4]
    else $error("result not from gain and offset");
  chk_sensor_off_hold: assert property (analog_power_down_o[1] // [RL16]
    |=> $stable(temperature_result_o))
    else $error("refresh while sensor off");
  chk_interval: assert property (upd |=> st_q.frames == 8'h00 ##0 !upd) // [RL3]
    else $error("interval not restarted");
  chk_deep_sleep: assert property (system_power_down_o[7] && system_power_down_o[5] // [RL10]
    && $stable(system_power_down_o) |=> deep_sleep_o)
    else $error("deep sleep not entered");
  // the write that enters sleep still finishes its own acknowledge
  chk_sleep_silent: assert property (deep_sleep_o && $past(deep_sleep_o) // [RL10]
    && st_q.bus != pwr_temp_pkg::BUS_ACK |-> sda_oe_n_o)
    else $error("bus answered in deep sleep");
  chk_sleep_no_ack: assert property (deep_sleep_o && st_q.bus == pwr_temp_pkg::BUS_ADDR // [RL10]
    |=> st_q.bus != pwr_temp_pkg::BUS_ACK)
    else $error("address acknowledged in deep sleep");
  chk_wake_clear: assert property (wake |=> !system_power_down_o[7] ##1 !deep_sleep_o) // [RL11]
    else $error("address did not wake");
endmodule // pwr_temp_ctrl

// ==== rtl/pwr_temp_pkg.sv ====
// constants, types and register map of the power-down and temperature readout block
// assumes one 100 MHz system clock; all pins arrive from outside that clock's domain
package pwr_temp_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_GAIN = 8'h14; // sensor_gain_divider
  localparam logic [7:0] REG_OFFSET = 8'h15; // sensor_offset
  localparam logic [7:0] REG_UPDATE = 8'h16; // frames_per_update
  localparam logic [7:0] REG_TEMP = 8'h17; // temperature_result, read only
  localparam logic [7:0] REG_ANALOG = 8'h18; // analog_power_down
  localparam logic [7:0] REG_SYSTEM = 8'h19; // system_power_down
  // reset values
  localparam logic [5:0] GAIN_RST = 6'h17;
  localparam logic [7:0] OFFSET_RST = 8'h3A;
  localparam logic [7:0] UPDATE_RST = 8'hFF;
  localparam logic [7:0] PD_RST = 8'h00;
  localparam logic [7:0] UPDATE_MIN = 8'h02; // lowest valid frames_per_update
  localparam logic [7:0] TEMP_MAX = 8'hFF; // saturated high reading
  // analog_power_down bit positions
  localparam int ANA_CUR_LIMIT = 7;
  localparam int ANA_PEAK_CUR = 6;
  localparam int ANA_CATHODE_GEN = 5;
  localparam int ANA_VREF = 4;
  localparam int ANA_GAMMA = 3;
  localparam int ANA_CATHODE_SEN = 2;
  localparam int ANA_THERM_SENSOR = 1;
  localparam int ANA_THERM_REF = 0;
  // system_power_down bit positions
  localparam int SYS_ALL_OFF = 7;
  localparam int SYS_VIDEO_RX = 6;
  localparam int SYS_REGULATOR = 5;
  localparam int SYS_RAMP_BUF = 4;
  localparam int SYS_RAMP_AMP = 3;
  localparam int SYS_RAMP_DAC = 2;
  localparam int SYS_POR_HIGH = 1;
  localparam int SYS_POR_LOW = 0;
  // serial bus address, value arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2C;
  // sensor scaling: code*gain >> shift, plus offset, plus fixed bias
  localparam int GAIN_SHIFT = 4;
  localparam logic signed [11:0] SENSOR_BIAS = -12'sh010;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    BUS_IDLE, BUS_ADDR, BUS_ACK, BUS_RX, BUS_TX, BUS_MACK, BUS_RLOAD
  } bus_state_t;
  // synchronised pins and their previous values
  typedef struct packed {
    logic [1:0] scl;
    logic [1:0] sda;
    logic [1:0] frame;
    logic [7:0] code1;
    logic [7:0] code2;
    logic scl_p;
    logic sda_p;
    logic frame_p;
  } pins_t;
  // software-visible registers
  typedef struct packed {
    logic [5:0] gain;
    logic [7:0] offset;
    logic [7:0] update;
    logic [7:0] temp;
    logic [7:0] analog;
    logic [7:0] system;
  } regs_t;
  // whole module state
  typedef struct packed {
    pins_t pin;
    regs_t rg;
    bus_state_t bus;
    logic [2:0] bitcnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic have_ptr;
    logic rw;
    logic ack_on;
    logic drive;
    logic [7:0] frames;
    logic sleep;
  } state_t;
endpackage

// ==== sim/i2c_host_model.sv ====
// host side of the serial control bus: an open-drain master for the bench
// assumes the device clock as timebase and pull-ups on both lines
`timescale 1ns/10ps
module i2c_host_model (
  input wire logic clk_i,
  input wire logic sda_oe_n_i,
  input wire logic sda_drv_i,
  output logic scl_o,
  output logic sda_o
);
  // ****************************************
  // line levels
  // ****************************************
  logic sda_q; // high = host lets go, pull-up wins
  logic scl_q; // stands high between transfers
  assign scl_o = scl_q;
  // wired-and: low when either party pulls down
  assign sda_o = sda_q & (sda_oe_n_i | sda_drv_i);
  initial begin
    sda_q = 1'b1;
    scl_q = 1'b1;
  end
  // ****************************************
  // bus cycles
  // ****************************************
  // quarter of the 160 ns bit period
  task automatic qtr();
    repeat (4) @(posedge clk_i);
  endtask
  // start, also repeated start from scl low
  task automatic start();
    sda_q <= 1'b1;
    qtr();
    scl_q <= 1'b1;
    qtr();
    sda_q <= 1'b0;
    qtr();
    scl_q <= 1'b0;
    qtr();
  endtask
  task automatic stop();
    sda_q <= 1'b0;
    qtr();
    scl_q <= 1'b1;
    qtr();
    sda_q <= 1'b1;
    qtr();
  endtask
  // one bit out, line sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_q <= b;
    qtr();
    scl_q <= 1'b1;
    qtr();
    r = sda_o;
    qtr();
    scl_q <= 1'b0;
    qtr();
  endtask
  // byte out msb first, ack returned high when pulled
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // byte in, then our ack (0) or nack (1)
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // i2c_host_model

// ==== sim/tb_top.sv ====
// bench for pwr_temp_ctrl: register access, refresh timing, sleep and wake
// assumes i2c_host_model on the bus and pwr_temp_pkg compiled first
`timescale 1ns/10ps
module tb_top;
  logic clk_sys_i, nrst_i, frame_q, scl, sda, sda_drv, sda_oe_n, deep_sleep;
  logic [7:0] code_q, temp, ana, sys, v, w;
  logic k;
  int fails = 0;
  int n_checks = 0;
  int n;
  logic [31:0] seed = 32'h3b7a;
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  i2c_host_model host (.clk_i(clk_sys_i), .sda_oe_n_i(sda_oe_n), .sda_drv_i(sda_drv),
    .scl_o(scl), .sda_o(sda));
  pwr_temp_ctrl dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_drv), .sda_oe_n_o(sda_oe_n), .frame_sync_i(frame_q),
    .sensor_code_i(code_q), .temperature_result_o(temp), .analog_power_down_o(ana),
    .system_power_down_o(sys), .deep_sleep_o(deep_sleep));
  // ****************************************
  // helpers and reference model
  // ****************************************
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // scaled code plus offset, clipped to the 8-bit range
  function automatic logic [7:0] temp_model(int code, int gain, int off);
    int t;
    t = ((code * gain) >> 4) + off - 16;
    if (t < 0) t = 0;
    if (t > 255) t = 255;
    return t[7:0];
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] dat, input logic ack);
    logic k1, k2, k3;
    host.start();
    host.wbyte({pwr_temp_pkg::DEV_ADDR, 1'b0}, k1);
    host.wbyte(a, k2);
    host.wbyte(dat, k3);
    host.stop();
    chk("write ack", {15'h0000, ack}, {15'h0000, k1 & k2 & k3});
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] e);
    logic k1, k2, k3;
    logic [7:0] r;
    host.start();
    host.wbyte({pwr_temp_pkg::DEV_ADDR, 1'b0}, k1);
    host.wbyte(a, k2);
    host.start();
    host.wbyte({pwr_temp_pkg::DEV_ADDR, 1'b1}, k3);
    host.rbyte(1'b1, r);
    host.stop();
    chk("read ack", 16'h0001, {15'h0000, k1 & k2 & k3});
    chk(what, e, r);
  endtask
  // one frame; the sync line rests low between frames
  task automatic frame();
    repeat (4) @(posedge clk_sys_i);
    frame_q <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    frame_q <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
  endtask
  task automatic wait_refresh(input logic [7:0] e, output int cnt);
    cnt = 0;
    while (temp !== e && cnt < 600) begin
      frame();
      cnt++;
    end
    chk("refreshed result", e, temp);
    if (temp !== e) end_sim();
  endtask
  // sync on two values in turn, then count frames to the next refresh
  task automatic interval(input logic [7:0] g, input logic [7:0] o, input logic [7:0] u,
    input logic wr);
    logic [7:0] ca, cb;
    int c;
    ca = rnd();
    cb = ~ca;
    if (wr) begin
      reg_wr(pwr_temp_pkg::REG_GAIN, g, 1'b1);
      reg_wr(pwr_temp_pkg::REG_OFFSET, o, 1'b1);
      reg_wr(pwr_temp_pkg::REG_UPDATE, u, 1'b1);
    end
    code_q <= ca;
    wait_refresh(temp_model(ca, g[5:0], o), c);
    code_q <= cb;
    wait_refresh(temp_model(cb, g[5:0], o), c);
    code_q <= ca;
    wait_refresh(temp_model(ca, g[5:0], o), c);
    chk("frames per refresh", 16'(u) + 16'h0001, 16'(c));
    $display("test interval %h done", u);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    nrst_i = 1'b0;
    frame_q = 1'b0;
    code_q = 8'h00;
    repeat (12) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    // reset values through pins and bus
    chk("analog pins", 8'h00, ana);
    chk("system pins", 8'h00, sys);
    rd_chk("gain", pwr_temp_pkg::REG_GAIN, {2'b00, pwr_temp_pkg::GAIN_RST});
    rd_chk("offset", pwr_temp_pkg::REG_OFFSET, pwr_temp_pkg::OFFSET_RST);
    rd_chk("update", pwr_temp_pkg::REG_UPDATE, pwr_temp_pkg::UPDATE_RST);
    rd_chk("analog", pwr_temp_pkg::REG_ANALOG, 8'h00);
    rd_chk("system", pwr_temp_pkg::REG_SYSTEM, 8'h00);
    rd_chk("unmapped", 8'h30, 8'h00);
    $display("test reset done");
    // default refresh of 255 then one more frame
    interval({2'b00, pwr_temp_pkg::GAIN_RST}, pwr_temp_pkg::OFFSET_RST,
      pwr_temp_pkg::UPDATE_RST, 1'b0);
    interval(8'h10, 8'h10, pwr_temp_pkg::UPDATE_MIN + (rnd() & 8'h0f), 1'b1);
    interval(8'h13, 8'h22, pwr_temp_pkg::UPDATE_MIN, 1'b1);
    // saturation at both ends
    reg_wr(pwr_temp_pkg::REG_GAIN, 8'hff, 1'b1);
    rd_chk("gain width", pwr_temp_pkg::REG_GAIN, 8'h3f);
    reg_wr(pwr_temp_pkg::REG_OFFSET, 8'hff, 1'b1);
    code_q <= 8'hff;
    wait_refresh(pwr_temp_pkg::TEMP_MAX, n);
    reg_wr(pwr_temp_pkg::REG_OFFSET, 8'h00, 1'b1);
    code_q <= 8'h00;
    wait_refresh(8'h00, n);
    // result register is read only
    reg_wr(pwr_temp_pkg::REG_TEMP, 8'h5a, 1'b1);
    rd_chk("result", pwr_temp_pkg::REG_TEMP, 8'h00);
    $display("test saturate done");
    // sensor off keeps last result
    v = rnd() | 8'h02;
    reg_wr(pwr_temp_pkg::REG_ANALOG, v, 1'b1);
    chk("analog pins", v, ana);
    code_q <= 8'hff;
    repeat (6) frame();
    chk("held result", 8'h00, temp);
    $display("test sensor off done");
    // system bits without sleep
    w = rnd() & 8'h7f;
    reg_wr(pwr_temp_pkg::REG_SYSTEM, w, 1'b1);
    chk("system pins", w, sys);
    w = (rnd() & 8'h5f) | 8'h80;
    reg_wr(pwr_temp_pkg::REG_SYSTEM, w, 1'b1);
    chk("system pins", w, sys);
    chk("no sleep", 8'h00, deep_sleep);
    // deep sleep, foreign address, then own address wakes
    w = rnd() | 8'ha0;
    reg_wr(pwr_temp_pkg::REG_SYSTEM, w, 1'b1);
    chk("sleep", 8'h01, deep_sleep);
    host.start();
    host.wbyte({pwr_temp_pkg::DEV_ADDR ^ 7'h01, 1'b0}, k);
    host.stop();
    chk("foreign ack", 16'h0000, {15'h0000, k});
    chk("still asleep", {w, 8'h01}, {sys, 7'h00, deep_sleep});
    reg_wr(pwr_temp_pkg::REG_ANALOG, 8'h00, 1'b0);
    chk("woken", {w & 8'h7f, 8'h00}, {sys, 7'h00, deep_sleep});
    rd_chk("analog kept", pwr_temp_pkg::REG_ANALOG, v);
    rd_chk("system kept", pwr_temp_pkg::REG_SYSTEM, w & 8'h7f);
    $display("test sleep done");
    end_sim();
  end
endmodule // tb_top
